// ==== core/ssalu_cfg.svh ====
`ifndef SSALU_CFG_SVH
`define SSALU_CFG_SVH
`define SSALU_DATA_W 8
`define SSALU_ADDR_W 8
`define SSALU_NIB_W 4
`define SSALU_MEM_DEPTH 256
`define SSALU_MSB 7
`define SSALU_FLAGS_RST 4'h0
`define SSALU_WREG_RST 8'h00
`define SSALU_FLG_Z 0
`define SSALU_FLG_C 1
`define SSALU_FLG_HR 2
`define SSALU_FLG_SW 3
`endif

// ==== core/ssalu_pkg.sv ====
`include "ssalu_cfg.svh"
package ssalu_pkg;
  typedef enum logic [2:0]
  {
    SSALU_OP_NONE,
    SSALU_OP_SHL_MEM,
    SSALU_OP_SHLC_MEM,
    SSALU_OP_SWAP_WREG,
    SSALU_OP_SWAP_MEM
  } ssalu_op_t;

  typedef enum logic [1:0]
  {
    SSALU_IDLE,
    SSALU_READ,
    SSALU_WRITE
  } ssalu_state_t;

  function automatic logic [`SSALU_DATA_W-1:0] ssalu_swap_nib(
    input logic [`SSALU_DATA_W-1:0] v
  );
    ssalu_swap_nib = {v[`SSALU_NIB_W-1:0], v[`SSALU_DATA_W-1:`SSALU_NIB_W]};
  endfunction
endpackage

// ==== core/ssalu_unit.sv ====
`timescale 1ns/10ps
`include "ssalu_cfg.svh"
module ssalu_unit
  import ssalu_pkg::*;
(
  input  wire ssalu_op_t                 op,
  input  wire logic [`SSALU_DATA_W-1:0]  operand,
  input  wire logic                      carry_in,
  output logic      [`SSALU_DATA_W-1:0]  result,
  output logic                           carry_out,
  output logic                           carry_we
);
  always_comb
  begin
    result    = operand;
    carry_out = carry_in;
    carry_we  = 1'b0;
    unique case (op)
      SSALU_OP_SHL_MEM:
      begin
        result    = {operand[`SSALU_DATA_W-2:0], 1'b0};
        carry_out = operand[`SSALU_MSB];
        carry_we  = 1'b1;
      end
      SSALU_OP_SHLC_MEM:
      begin
        result    = {operand[`SSALU_DATA_W-2:0], carry_in};
        carry_out = operand[`SSALU_MSB];
        carry_we  = 1'b1;
      end
      SSALU_OP_SWAP_WREG, SSALU_OP_SWAP_MEM:
        result = ssalu_swap_nib(operand);
      SSALU_OP_NONE:
        result = operand;
    endcase
  end
endmodule

// ==== core/ssalu_core.sv ====
`timescale 1ns/10ps
`include "ssalu_cfg.svh"
// Summary of operation
// - memory shift left, zero in, msb to carry
// - memory shift left through carry flag
// - memory shifts change only carry flag
// - working register nibbles exchanged
// - working register swap keeps all flags
// - memory byte nibble swap, written back
module ssalu_core
  import ssalu_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      start,
  input  wire ssalu_op_t                 op,
  input  wire logic [`SSALU_ADDR_W-1:0]  addr,
  input  wire logic                      mem_load,
  input  wire logic [`SSALU_ADDR_W-1:0]  load_addr,
  input  wire logic [`SSALU_DATA_W-1:0]  load_data,
  input  wire logic                      wreg_load,
  input  wire logic [`SSALU_DATA_W-1:0]  wreg_data,
  input  wire logic [3:0]                flags_load_val,
  input  wire logic                      flags_load,
  input  wire logic [`SSALU_ADDR_W-1:0]  peek_addr,
  output logic      [`SSALU_DATA_W-1:0]  peek_data,
  output logic      [`SSALU_DATA_W-1:0]  working_register,
  output logic                           zero_flag,
  output logic                           carry_flag,
  output logic                           half_ripple_flag,
  output logic                           signed_wrap_flag,
  output logic                           busy,
  output logic                           done
);
  logic [`SSALU_DATA_W-1:0] mem [`SSALU_MEM_DEPTH];
  ssalu_state_t             state;
  ssalu_op_t                cur_op;
  logic [`SSALU_ADDR_W-1:0] cur_addr;
  logic [`SSALU_DATA_W-1:0] operand;
  logic [`SSALU_DATA_W-1:0] result;
  logic                     next_carry;
  logic                     carry_we;
  logic                     commit;
  logic                     on_mem;
  // one reset word, picked apart per flag so every flag resets in one place
  localparam logic [3:0]    flags_rst = `SSALU_FLAGS_RST;

  // operand latched in READ so memory timing is a plain registered read
  assign on_mem = (cur_op != SSALU_OP_SWAP_WREG);
  assign commit = (state == SSALU_WRITE);
  assign busy   = (state != SSALU_IDLE);

  ssalu_unit u_unit
  (
    .op        (cur_op),
    .operand   (operand),
    .carry_in  (carry_flag),
    .result    (result),
    .carry_out (next_carry),
    .carry_we  (carry_we)
  );

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state    <= SSALU_IDLE;
      cur_op   <= SSALU_OP_NONE;
      cur_addr <= '0;
    end
    else
    begin
      unique case (state)
        SSALU_IDLE:
          if (start && op != SSALU_OP_NONE)
          begin
            cur_op   <= op;
            cur_addr <= addr;
            state    <= SSALU_READ;
          end
        SSALU_READ:
          state <= SSALU_WRITE;
        SSALU_WRITE:
          state <= SSALU_IDLE;
        default:
          state <= SSALU_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      operand <= `SSALU_WREG_RST;
    else if (state == SSALU_READ)
      operand <= on_mem ? mem[cur_addr] : working_register;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      done <= 1'b0;
    else
      done <= commit;
  end

  // data and flag written in the same edge
  always_ff @(posedge ref_clk)
  begin
    if (commit && on_mem)
      mem[cur_addr] <= result;
    else if (mem_load && !busy)
      mem[load_addr] <= load_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      working_register <= `SSALU_WREG_RST;
    else if (commit && !on_mem)
      working_register <= result;
    else if (wreg_load && !busy)
      working_register <= wreg_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      carry_flag <= flags_rst[`SSALU_FLG_C];
    else if (commit && carry_we)
      carry_flag <= next_carry;
    else if (flags_load && !busy)
      carry_flag <= flags_load_val[`SSALU_FLG_C];
  end

  // zero, half-ripple and signed-wrap are never written by these operations
  // loads stand in for the rest of the core and are ignored while busy
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      zero_flag        <= flags_rst[`SSALU_FLG_Z];
      half_ripple_flag <= flags_rst[`SSALU_FLG_HR];
      signed_wrap_flag <= flags_rst[`SSALU_FLG_SW];
    end
    else if (flags_load && !busy)
    begin
      zero_flag        <= flags_load_val[`SSALU_FLG_Z];
      half_ripple_flag <= flags_load_val[`SSALU_FLG_HR];
      signed_wrap_flag <= flags_load_val[`SSALU_FLG_SW];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    peek_data <= mem[peek_addr];
  end

  chk_shl_result: assert property (@(posedge ref_clk) disable iff (rst)
    commit && cur_op == SSALU_OP_SHL_MEM |=> mem[$past(cur_addr)] ==
      {$past(operand[6:0]), 1'b0} && carry_flag == $past(operand[7]))
    else $error("shift left result wrong");
  chk_shlc_result: assert property (@(posedge ref_clk) disable iff (rst)
    commit && cur_op == SSALU_OP_SHLC_MEM |=> mem[$past(cur_addr)] ==
      {$past(operand[6:0]), $past(carry_flag)} && carry_flag == $past(operand[7]))
    else $error("shift through carry wrong");
  chk_shift_flags: assert property (@(posedge ref_clk) disable iff (rst)
    busy |=> $stable(zero_flag) && $stable(half_ripple_flag) && $stable(signed_wrap_flag))
    else $error("shift touched other flags");
  chk_swap_wreg: assert property (@(posedge ref_clk) disable iff (rst)
    commit && cur_op == SSALU_OP_SWAP_WREG |=>
      working_register == {$past(operand[3:0]), $past(operand[7:4])})
    else $error("register swap wrong");
  chk_swap_flags: assert property (@(posedge ref_clk) disable iff (rst)
    commit && cur_op == SSALU_OP_SWAP_WREG |=> $stable(carry_flag) && $stable(zero_flag)
      && $stable(half_ripple_flag) && $stable(signed_wrap_flag))
    else $error("register swap changed flags");
  chk_swap_mem: assert property (@(posedge ref_clk) disable iff (rst)
    commit && cur_op == SSALU_OP_SWAP_MEM |=>
      mem[$past(cur_addr)] == {$past(operand[3:0]), $past(operand[7:4])})
    else $error("memory swap wrong");
  chk_op_latency: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && start && op != SSALU_OP_NONE |=> busy ##1 busy ##1 (!busy && done))
    else $error("operation did not finish in two cycles");
  chk_done_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    done |=> !done)
    else $error("done longer than one cycle");

  // side effects, refused requests and reset
  chk_swap_mem_flags: assert property (@(posedge ref_clk) disable iff (rst)
    commit && cur_op == SSALU_OP_SWAP_MEM |=> $stable(carry_flag) && $stable(zero_flag)
      && $stable(half_ripple_flag) && $stable(signed_wrap_flag))
    else $error("memory swap changed flags");
  chk_wreg_kept_mem: assert property (@(posedge ref_clk) disable iff (rst)
    commit && on_mem |=> $stable(working_register))
    else $error("memory operation wrote working register");
  chk_mem_kept_wreg: assert property (@(posedge ref_clk) disable iff (rst)
    commit && !on_mem |=> mem[$past(cur_addr)] == $past(mem[cur_addr]))
    else $error("register swap wrote memory");
  chk_carry_untouched: assert property (@(posedge ref_clk) disable iff (rst)
    commit && !carry_we |=> $stable(carry_flag))
    else $error("swap wrote carry");
  chk_no_early_write: assert property (@(posedge ref_clk) disable iff (rst)
    busy && !commit |=> $stable(working_register) && $stable(carry_flag))
    else $error("result written before commit");
  chk_done_follows: assert property (@(posedge ref_clk) disable iff (rst)
    commit |=> done && !busy)
    else $error("done missing after commit");
  chk_none_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    !busy && start && op == SSALU_OP_NONE |=> !busy && !done)
    else $error("empty operation started");
  chk_reset_idle: assert property (@(posedge ref_clk)
    rst |=> !busy && !done && working_register == `SSALU_WREG_RST)
    else $error("reset left an operation running");

  cov_shl: cover property (@(posedge ref_clk) commit && cur_op == SSALU_OP_SHL_MEM);
  cov_shlc: cover property (@(posedge ref_clk) commit && cur_op == SSALU_OP_SHLC_MEM
    && carry_flag);
  cov_swap_wreg: cover property (@(posedge ref_clk) commit && cur_op == SSALU_OP_SWAP_WREG);
  cov_swap_mem: cover property (@(posedge ref_clk) commit && cur_op == SSALU_OP_SWAP_MEM);
  cov_refused_load: cover property (@(posedge ref_clk) busy
    && (wreg_load || flags_load || mem_load));
endmodule

// ==== tb/ssalu_tb.sv ====
`timescale 1ns/10ps
`include "ssalu_cfg.svh"
module testbench
  import ssalu_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       start = 1'b0;
  ssalu_op_t  op = SSALU_OP_NONE;
  logic [7:0] addr = 8'h00;
  logic       mem_load = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [7:0] load_data = 8'h00;
  logic       wreg_load = 1'b0;
  logic [7:0] wreg_data = 8'h00;
  logic [3:0] flags_load_val = 4'h0;
  logic       flags_load = 1'b0;
  logic [7:0] peek_addr = 8'h00;
  logic [7:0] peek_data;
  logic [7:0] working_register;
  logic       zero_flag;
  logic       carry_flag;
  logic       half_ripple_flag;
  logic       signed_wrap_flag;
  logic       busy;
  logic       done;
  logic [3:0] flags;
  int         failures = 0;
  int         checked = 0;
  int         cycles = 0;

  assign flags = {signed_wrap_flag, half_ripple_flag, carry_flag, zero_flag};

  ssalu_core dut (.ref_clk, .rst, .start, .op, .addr, .mem_load, .load_addr, .load_data,
    .wreg_load, .wreg_data, .flags_load_val, .flags_load, .peek_addr, .peek_data,
    .working_register, .zero_flag, .carry_flag, .half_ripple_flag, .signed_wrap_flag,
    .busy, .done);

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // whole suite takes about eighty cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic load(input logic [7:0] a, input logic [7:0] d, input logic [7:0] w,
                      input logic [3:0] fl);
    @(negedge ref_clk);
    mem_load = 1'b1;
    wreg_load = 1'b1;
    flags_load = 1'b1;
    load_addr = a;
    load_data = d;
    wreg_data = w;
    flags_load_val = fl;
    @(negedge ref_clk);
    mem_load = 1'b0;
    wreg_load = 1'b0;
    flags_load = 1'b0;
  endtask

  task automatic run(input ssalu_op_t o, input logic [7:0] a);
    int n;
    @(negedge ref_clk);
    start = 1'b1;
    op = o;
    addr = a;
    @(negedge ref_clk);
    start = 1'b0;
    cmp("busy", 8'h01, {7'h00, busy});
    n = 0;
    while (done !== 1'b1 && n < 8)
    begin
      @(negedge ref_clk);
      n++;
    end
    // done shows two cycles after the cycle in which start was dropped
    cmp("latency", 8'h02, n[7:0]);
    cmp("busy end", 8'h00, {7'h00, busy});
  endtask

  task automatic t_mem(input ssalu_op_t o, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] fl);
    logic [7:0] er;
    logic [3:0] ef;
    logic [7:0] got;
    er = (o == SSALU_OP_SWAP_MEM) ? {d[3:0], d[7:4]}
                                 : {d[6:0], (o == SSALU_OP_SHLC_MEM) & fl[1]};
    // nibble swap of memory leaves every flag alone
    ef = (o == SSALU_OP_SWAP_MEM) ? fl : {fl[3:2], d[7], fl[0]};
    load(a, d, 8'h5A, fl);
    run(o, a);
    cmp("flags", {4'h0, ef}, {4'h0, flags});
    cmp("wreg", 8'h5A, working_register);
    peek_addr = a;
    @(negedge ref_clk);
    got = peek_data;
    cmp("mem", er, got);
    $display("test %s done", o.name());
  endtask

  task automatic t_wreg(input logic [7:0] w, input logic [3:0] fl);
    load(8'h00, 8'h00, w, fl);
    run(SSALU_OP_SWAP_WREG, 8'h00);
    cmp("wreg", {w[3:0], w[7:4]}, working_register);
    cmp("flags", {4'h0, fl}, {4'h0, flags});
    $display("test swap_wreg done");
  endtask

  task automatic t_none();
    load(8'h50, 8'hC3, 8'h77, 4'h5);
    @(negedge ref_clk);
    start = 1'b1;
    op = SSALU_OP_NONE;
    addr = 8'h50;
    peek_addr = 8'h50;
    @(negedge ref_clk);
    start = 1'b0;
    repeat (3)
    begin
      cmp("none busy", 8'h00, {6'h00, busy, done});
      @(negedge ref_clk);
    end
    cmp("none wreg", 8'h77, working_register);
    cmp("none flags", 8'h05, {4'h0, flags});
    cmp("none mem", 8'hC3, peek_data);
    $display("test none_op done");
  endtask

  // loads and a second start while busy are refused; start in the done cycle is taken
  task automatic t_refuse();
    load(8'h40, 8'h96, 8'h12, 4'h0);
    @(negedge ref_clk);
    start = 1'b1;
    op = SSALU_OP_SHL_MEM;
    addr = 8'h40;
    @(negedge ref_clk);
    op = SSALU_OP_SWAP_WREG;
    mem_load = 1'b1;
    wreg_load = 1'b1;
    flags_load = 1'b1;
    load_addr = 8'h40;
    load_data = 8'h00;
    wreg_data = 8'hEE;
    flags_load_val = 4'hF;
    repeat (2) @(negedge ref_clk);
    mem_load = 1'b0;
    wreg_load = 1'b0;
    flags_load = 1'b0;
    peek_addr = 8'h40;
    cmp("refused done", 8'h01, {7'h00, done});
    cmp("refused wreg", 8'h12, working_register);
    cmp("refused flags", 8'h02, {4'h0, flags});
    @(negedge ref_clk);
    start = 1'b0;
    cmp("refused mem", 8'h2C, peek_data);
    repeat (2) @(negedge ref_clk);
    cmp("back to back wreg", 8'h21, working_register);
    cmp("back to back done", 8'h01, {7'h00, done});
    cmp("back to back flags", 8'h02, {4'h0, flags});
    $display("test refused_loads done");
  endtask

  initial
  begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    cmp("rst wreg", 8'h00, working_register);
    cmp("rst flags", 8'h00, {4'h0, flags});
    // both carry directions, plus top and bottom addresses
    t_mem(SSALU_OP_SHL_MEM, 8'h10, 8'hB5, 4'hD);
    t_mem(SSALU_OP_SHL_MEM, 8'hFF, 8'h7F, 4'h2);
    t_mem(SSALU_OP_SHLC_MEM, 8'h20, 8'h81, 4'h2);
    t_mem(SSALU_OP_SHLC_MEM, 8'h00, 8'h40, 4'hB);
    t_mem(SSALU_OP_SHLC_MEM, 8'h21, 8'hC3, 4'hD);
    t_mem(SSALU_OP_SWAP_MEM, 8'h30, 8'hA5, 4'hF);
    t_mem(SSALU_OP_SWAP_MEM, 8'h31, 8'h1E, 4'h0);
    t_wreg(8'h3C, 4'hA);
    t_wreg(8'hF0, 4'h5);
    t_none();
    t_refuse();
    summarize();
  end
endmodule
